// ---- logic/special_register_bank_map.svh ----
`ifndef SPECIAL_REGISTER_BANK_MAP_SVH
`define SPECIAL_REGISTER_BANK_MAP_SVH

// ---------------------------------------------------------------
// bank-1 operation register addresses (file register space)
// ---------------------------------------------------------------
`define FR_FIRST_PULSE_DUTY   4'h8
`define FR_SECOND_PULSE_DUTY  4'h9
`define FR_CONV_CHANNEL_SEL   4'hA
`define FR_CONV_HIGH_BYTE     4'hB
`define FR_CONV_LOW_BITS      4'hC
`define FR_NVM_COMMAND        4'hE

// ---------------------------------------------------------------
// bank-0 control register addresses (generic control space)
// ---------------------------------------------------------------
`define CR_DATA_LINE_DIR      4'h5
`define CR_PORT6_DIR          4'h6

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define RST_PULSE_DUTY        8'h00
`define RST_CONV_CHANNEL_SEL  8'h00
`define RST_NVM_COMMAND       8'h00
`define RST_TIMING_SETUP      8'h3F
`define RST_DATA_LINE_DIR     8'h03
`define RST_PORT6_DIR         8'hFF

// ---------------------------------------------------------------
// field positions and masks
// ---------------------------------------------------------------
`define CH_READY_BIT          7
`define CH_TOKEN_BIT          6
`define SETUP_INTR_OFF_BIT    6
`define SETUP_WRITE_MASK      8'h7F
`define DATA_LINE_DIR_MASK    8'h03
`define PORT6_DIR_FIXED       8'h01
`define CH_FIRST_PORT6        5'h02
`define CH_LAST_PORT6         5'h08
`define CH_FIRST_PORT7        5'h09
`define CH_LAST_PORT7         5'h10

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CORE_CLK_MHZ          25
`define NVM_READ_TIME_US      1000
`define NVM_WRITE_TIME_US     9000
`define NVM_ERASE_TIME_US     128000

`endif

// ---- logic/special_register_bank_pkg.sv ----
package special_register_bank_pkg;

	// one register access request: strobes, address and write data
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [3:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	// converter completion with its 10-bit result
	typedef struct packed {
		logic       done;
		logic [9:0] result;
	} conv_done_t;

	// non-volatile memory operations
	typedef enum logic [1:0] {
		NVM_READ    = 2'h0,
		NVM_WRITE   = 2'h1,
		NVM_ERASE   = 2'h2,
		NVM_DISABLE = 2'h3
	} nvm_op_t;

	// converter control states, one-hot
	typedef enum logic [1:0] {
		CONV_IDLE = 2'b01,
		CONV_BUSY = 2'b10
	} conv_state_t;

endpackage : special_register_bank_pkg

// ---- logic/special_register_bank.sv ----
`timescale 1ns/1ps
`include "special_register_bank_map.svh"
// Contract
// - two duty registers, reset to zero
// - channel codes: 0 off, 1 reserved, pins
// - token flag set by hardware, software clears
// - hardware clears ready bit after result stored
// - no conversion on disabled or reserved channel
// - high register shows result bits nine..two
// - low register shows bits one, zero on top
// - memory command selects read/write/erase/disable
// - setup and control registers by own instructions
// - setup holds watchdog and tick prescalers, 0x3F
// - prescaler code gives power-of-two divisions
// - setup bit six disables interrupts
// - direction bit one is input
// - data-line direction only bits zero, one
// - port-6 direction bit zero fixed one
module special_register_bank
	import special_register_bank_pkg::*;
#(
	parameter int unsigned NVM_READ_CYCLES  = `NVM_READ_TIME_US * `CORE_CLK_MHZ,
	parameter int unsigned NVM_WRITE_CYCLES = `NVM_WRITE_TIME_US * `CORE_CLK_MHZ,
	parameter int unsigned NVM_ERASE_CYCLES = `NVM_ERASE_TIME_US * `CORE_CLK_MHZ
) (
	// clock and reset
	input  wire logic        I_CORE_CLK,
	input  wire logic        I_ARST_N,
	// file register access (bank-1 operation registers)
	input  wire reg_req_t    I_FILE_REQ,
	input  wire logic        I_BANK1_SEL,
	// generic control register instructions
	input  wire reg_req_t    I_CTRL_REQ,
	// timing setup instructions
	input  wire logic        I_SETUP_WR,
	input  wire logic        I_SETUP_RD,
	input  wire logic [7:0]  I_SETUP_WDATA,
	// interrupt instructions
	input  wire logic        I_INTR_OFF,
	input  wire logic        I_INTR_ON,
	input  wire logic        I_INTR_RET,
	// hardware events
	input  wire logic        I_TOKEN_SEEN,
	input  wire conv_done_t  I_CONV_DONE,
	// read data
	output logic [7:0]       O_RDATA,
	// pulse-width duty values
	output logic [7:0]       O_FIRST_PULSE_DUTY,
	output logic [7:0]       O_SECOND_PULSE_DUTY,
	// converter control
	output logic             O_CONV_START,
	output logic             O_CONV_BUSY,
	output logic [4:0]       O_CONV_CHANNEL,
	output logic [7:0]       O_CONV_P6_SEL,
	output logic [7:0]       O_CONV_P7_SEL,
	// memory command
	output nvm_op_t          O_NVM_OP,
	output logic [21:0]      O_NVM_OP_CYCLES,
	// prescalers and interrupt disable
	output logic [7:0]       O_WDOG_DIV,
	output logic [8:0]       O_TICK_DIV,
	output logic             O_INTR_OFF,
	// port directions, 1 = input
	output logic [1:0]       O_DATA_LINE_DIR,
	output logic [7:0]       O_PORT6_DIR
);

	// ---------------------------------------------------------------
	// access decode
	// ---------------------------------------------------------------
	logic file_wr;                  // bank-1 write strobe
	logic file_rd;                  // bank-1 read strobe
	logic ctrl_wr;                  // control write strobe
	logic wr_chsel;                 // write to channel select
	logic chan_ok;                  // written channel is a pin
	logic start_req;                // accepted conversion start

	// bank-1 registers only answer with bank 1 selected
	assign file_wr = I_FILE_REQ.wr & I_BANK1_SEL;
	assign file_rd = I_FILE_REQ.rd & I_BANK1_SEL;
	assign ctrl_wr = I_CTRL_REQ.wr;
	assign wr_chsel = file_wr && (I_FILE_REQ.addr == `FR_CONV_CHANNEL_SEL);

	// channel codes 2..16 are pins; 0, 1 and above 16 are not
	assign chan_ok = (I_FILE_REQ.wdata[4:0] >= `CH_FIRST_PORT6) &&
		(I_FILE_REQ.wdata[4:0] <= `CH_LAST_PORT7);

	// ---------------------------------------------------------------
	// state registers
	// ---------------------------------------------------------------
	logic [7:0]  duty1_ff;          // first duty value
	logic [7:0]  duty2_ff;          // second duty value
	logic [4:0]  chan_ff;           // converter channel field
	logic        token_ff;          // token seen flag
	conv_state_t conv_ff;           // converter control state
	conv_state_t nxt_conv;          // next converter state
	logic        start_ff;          // start pulse to converter
	logic [9:0]  result_ff;         // latest conversion result
	logic [7:0]  nvm_ff;            // memory command
	logic [7:0]  setup_ff;          // timing setup
	logic [1:0]  dldir_ff;          // data-line direction
	logic [7:1]  p6dir_ff;          // port-6 direction, bits 7..1
	logic [7:0]  rdata_ff;          // registered read data

	// ready bit mirrors a running conversion
	assign start_req = wr_chsel && I_FILE_REQ.wdata[`CH_READY_BIT] &&
		(conv_ff == CONV_IDLE) && chan_ok;

	// ---------------------------------------------------------------
	// duty registers
	// ---------------------------------------------------------------
	// plain storage, zero after reset
	always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			duty1_ff <= `RST_PULSE_DUTY;
			duty2_ff <= `RST_PULSE_DUTY;
		end else if (file_wr) begin
			// address picks the register
			if (I_FILE_REQ.addr == `FR_FIRST_PULSE_DUTY) begin
				duty1_ff <= I_FILE_REQ.wdata;
			end
			if (I_FILE_REQ.addr == `FR_SECOND_PULSE_DUTY) begin
				duty2_ff <= I_FILE_REQ.wdata;
			end
		end
	end

	// ---------------------------------------------------------------
	// converter channel field
	// ---------------------------------------------------------------
	// bit 5 is not stored and reads zero
	always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			chan_ff <= 5'(`RST_CONV_CHANNEL_SEL);
		end else if (wr_chsel) begin
			chan_ff <= I_FILE_REQ.wdata[4:0];
		end
	end

	// ---------------------------------------------------------------
	// token flag
	// ---------------------------------------------------------------
	// hardware set wins over a clearing write in the same cycle
	always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			token_ff <= 1'b0;
		end else if (I_TOKEN_SEEN) begin
			token_ff <= 1'b1;
		end else if (wr_chsel && !I_FILE_REQ.wdata[`CH_TOKEN_BIT]) begin
			token_ff <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// converter control state machine
	// ---------------------------------------------------------------
	// idle until a legal start, busy until the result lands
	always_comb begin
		nxt_conv = conv_ff;
		unique case (conv_ff)
			CONV_IDLE: begin
				// start only on a pin channel
				if (start_req) begin
					nxt_conv = CONV_BUSY;
				end
			end
			CONV_BUSY: begin
				// result stored, ready bit drops
				if (I_CONV_DONE.done) begin
					nxt_conv = CONV_IDLE;
				end
			end
			default: nxt_conv = CONV_IDLE; // corrupt code recovers to idle
		endcase
	end

	// state register and one-cycle start pulse to the converter
	always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			conv_ff  <= CONV_IDLE;
			start_ff <= 1'b0;
		end else begin
			conv_ff  <= nxt_conv;
			start_ff <= start_req;
		end
	end

	// result latched only for a running conversion
	always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			result_ff <= 10'h000;
		end else if (I_CONV_DONE.done && (conv_ff == CONV_BUSY)) begin
			result_ff <= I_CONV_DONE.result;
		end
	end

	// ---------------------------------------------------------------
	// memory command
	// ---------------------------------------------------------------
	always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			nvm_ff <= `RST_NVM_COMMAND;
		end else if (file_wr && (I_FILE_REQ.addr == `FR_NVM_COMMAND)) begin
			nvm_ff <= I_FILE_REQ.wdata;
		end
	end

	// ---------------------------------------------------------------
	// timing setup
	// ---------------------------------------------------------------
	// interrupt instructions override bit 6 of a setup write in the same cycle
	always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			setup_ff <= `RST_TIMING_SETUP;
		end else begin
			if (I_SETUP_WR) begin
				// only the setup write instruction reaches it, except bit 6
				setup_ff <= I_SETUP_WDATA & `SETUP_WRITE_MASK;
			end
			if (I_INTR_OFF) begin
				setup_ff[`SETUP_INTR_OFF_BIT] <= 1'b1;
			end else if (I_INTR_ON || I_INTR_RET) begin
				setup_ff[`SETUP_INTR_OFF_BIT] <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// port direction registers
	// ---------------------------------------------------------------
	// reached only by the generic control write
	always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			dldir_ff <= 2'(`RST_DATA_LINE_DIR);
			p6dir_ff <= 7'(`RST_PORT6_DIR >> 1);
		end else if (ctrl_wr) begin
			if (I_CTRL_REQ.addr == `CR_DATA_LINE_DIR) begin
				dldir_ff <= I_CTRL_REQ.wdata[1:0];
			end
			if (I_CTRL_REQ.addr == `CR_PORT6_DIR) begin
				p6dir_ff <= I_CTRL_REQ.wdata[7:1];
			end
		end
	end

	// ---------------------------------------------------------------
	// read data path
	// ---------------------------------------------------------------
	// one read per cycle; setup, control, then file order
	always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			rdata_ff <= 8'h00;
		end else if (I_SETUP_RD) begin
			rdata_ff <= setup_ff;
		end else if (I_CTRL_REQ.rd) begin
			unique case (I_CTRL_REQ.addr)
				`CR_DATA_LINE_DIR: rdata_ff <= {6'h00, dldir_ff};
				`CR_PORT6_DIR:     rdata_ff <= {p6dir_ff, 1'b1};
				default:           rdata_ff <= 8'h00;
			endcase
		end else if (file_rd) begin
			unique case (I_FILE_REQ.addr)
				`FR_FIRST_PULSE_DUTY:  rdata_ff <= duty1_ff;
				`FR_SECOND_PULSE_DUTY: rdata_ff <= duty2_ff;
				`FR_CONV_CHANNEL_SEL:  rdata_ff <= {conv_ff == CONV_BUSY,
					token_ff, 1'b0, chan_ff};
				`FR_CONV_HIGH_BYTE:    rdata_ff <= result_ff[9:2];
				`FR_CONV_LOW_BITS:     rdata_ff <= {result_ff[1:0], 6'h00};
				`FR_NVM_COMMAND:       rdata_ff <= nvm_ff;
				default:               rdata_ff <= 8'h00;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// channel pin decode
	// ---------------------------------------------------------------
	// one-hot pin select; port-6 pin 0 is never a channel
	for (genvar gi = 0; gi < 8; gi++) begin : g_chan
		if (gi == 0) begin : g_p60
			assign O_CONV_P6_SEL[gi] = 1'b0;
		end else begin : g_p6x
			assign O_CONV_P6_SEL[gi] = (chan_ff == 5'(gi + 1));
		end
		assign O_CONV_P7_SEL[gi] = (chan_ff == 5'(gi + 9));
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign O_RDATA             = rdata_ff;
	assign O_FIRST_PULSE_DUTY  = duty1_ff;
	assign O_SECOND_PULSE_DUTY = duty2_ff;
	assign O_CONV_START        = start_ff;
	assign O_CONV_BUSY         = (conv_ff == CONV_BUSY);
	assign O_CONV_CHANNEL      = chan_ff;
	assign O_NVM_OP            = nvm_op_t'(nvm_ff[1:0]);
	assign O_INTR_OFF          = setup_ff[`SETUP_INTR_OFF_BIT];
	assign O_DATA_LINE_DIR     = dldir_ff;
	assign O_PORT6_DIR         = {p6dir_ff, 1'b1};

	// watchdog divides by 2^n, tick counter by 2^(n+1)
	assign O_WDOG_DIV = 8'(8'h01 << setup_ff[2:0]);
	assign O_TICK_DIV = 9'(9'h002 << setup_ff[5:3]);

	// execution time of the selected memory operation
	always_comb begin
		unique case (O_NVM_OP)
			NVM_READ:    O_NVM_OP_CYCLES = 22'(NVM_READ_CYCLES);
			NVM_WRITE:   O_NVM_OP_CYCLES = 22'(NVM_WRITE_CYCLES);
			NVM_ERASE:   O_NVM_OP_CYCLES = 22'(NVM_ERASE_CYCLES);
			NVM_DISABLE: O_NVM_OP_CYCLES = 22'h000000;
		endcase
	end

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge I_CORE_CLK); endclocking
	default disable iff (!I_ARST_N);

	a_start_legal_chan: assert property (
		O_CONV_START |-> (O_CONV_CHANNEL >= 5'h02) && (O_CONV_CHANNEL <= 5'h10))
		else $error("conversion started on a non-pin channel");
	a_start_needs_write: assert property (
		O_CONV_START |-> $past(wr_chsel) && $past(I_FILE_REQ.wdata[7]))
		else $error("conversion start without a ready-bit write");
	a_done_clears_ready: assert property (
		(O_CONV_BUSY && I_CONV_DONE.done) |=> !O_CONV_BUSY &&
		(result_ff == $past(I_CONV_DONE.result)))
		else $error("ready bit or result wrong after completion");
	a_token_sticks: assert property (
		I_TOKEN_SEEN |=> token_ff) else $error("token flag lost");
	// read data shows the result as it stood on the read edge
	a_high_byte_read: assert property (
		(file_rd && I_FILE_REQ.addr == 4'hB && !I_SETUP_RD && !I_CTRL_REQ.rd)
		|=> O_RDATA == $past(result_ff[9:2]))
		else $error("high result byte misread");
	a_low_bits_read: assert property (
		(file_rd && I_FILE_REQ.addr == 4'hC && !I_SETUP_RD && !I_CTRL_REQ.rd)
		|=> O_RDATA == {$past(result_ff[1:0]), 6'h00})
		else $error("low result bits misread");
	a_intr_off_set: assert property (
		I_INTR_OFF |=> O_INTR_OFF) else $error("interrupt-off did not set disable");
	a_intr_on_clear: assert property (
		(!I_INTR_OFF && (I_INTR_ON || I_INTR_RET)) |=> !O_INTR_OFF)
		else $error("interrupt-on did not clear disable");
	a_p6_dir_write: assert property (
		(ctrl_wr && I_CTRL_REQ.addr == 4'h6) |=> O_PORT6_DIR == {$past(I_CTRL_REQ.wdata[7:1]), 1'b1})
		else $error("port-6 direction write wrong or pin 0 not an input");
	a_tick_ratio: assert property (
		O_TICK_DIV == 9'(2 * O_WDOG_DIV) || setup_ff[5:3] != setup_ff[2:0])
		else $error("tick and watchdog ratios disagree");
	a_result_hold: assert property (
		!(I_CONV_DONE.done && O_CONV_BUSY) |=> $stable(result_ff))
		else $error("result changed without completion");
	a_nvm_reset_read: assert property (
		$rose(I_ARST_N) |-> O_NVM_OP == NVM_READ)
		else $error("memory command not read after reset");

	c_conversion: cover property (O_CONV_START ##[1:20] !O_CONV_BUSY);
	c_token_clear: cover property (token_ff ##1 !token_ff);
	c_intr_cycle: cover property (O_INTR_OFF ##[1:10] !O_INTR_OFF);
	c_reject_start: cover property (wr_chsel && I_FILE_REQ.wdata[7] && !chan_ok);

endmodule : special_register_bank

// ---- test/test_special_register_bank.sv ----
`timescale 1ns/1ps
module test_special_register_bank
	import special_register_bank_pkg::*;
();
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic        clk, arst_n;        // core clock, reset
	reg_req_t    file_req, ctrl_req; // register strobes
	logic        bank1;              // bank select level
	logic        setup_wr, setup_rd; // setup strobes
	logic [7:0]  setup_wdata;        // setup write data
	logic [4:0]  evt;                // token, done, off, on, ret pulses
	conv_done_t  conv;               // completion with result
	logic [7:0]  rdata, duty1, duty2, p6sel, p7sel, wdiv, p6_dir;
	logic        start, busy, intr_q;
	logic [4:0]  chan;
	nvm_op_t     nvm_op;
	logic [21:0] nvm_cyc;
	logic [8:0]  tdiv;
	logic [1:0]  dl_dir;
	int          num_errors, checks_done, cycles, c;
	logic [9:0]  res, last_res;
	// one register per row: kind, address, reset, write, readback
	typedef struct {int k; logic [3:0] a; logic [7:0] r, d, e;} row_t;
	row_t rows [10] = '{
		'{0, 4'h8, 8'h00, 8'h5A, 8'h5A},
		'{0, 4'h9, 8'h00, 8'hA5, 8'hA5},
		'{0, 4'hE, 8'h00, 8'h01, 8'h01},
		'{0, 4'hB, 8'h00, 8'hFF, 8'h00},
		'{0, 4'hC, 8'h00, 8'hFF, 8'h00},
		'{0, 4'hA, 8'h00, 8'h3F, 8'h1F},
		'{1, 4'h5, 8'h03, 8'hFC, 8'h00},
		'{1, 4'h6, 8'hFF, 8'h00, 8'h01},
		'{1, 4'h7, 8'h00, 8'hFF, 8'h00},
		'{2, 4'h0, 8'h3F, 8'hC0, 8'h40}
	};
	int cyc_exp [4] = '{10, 20, 40, 0};

	// ----------------------------------------
	// design under test, short memory timings
	// ----------------------------------------
	special_register_bank #(.NVM_READ_CYCLES(10), .NVM_WRITE_CYCLES(20),
		.NVM_ERASE_CYCLES(40)) DUT (
		.I_CORE_CLK(clk), .I_ARST_N(arst_n), .I_FILE_REQ(file_req),
		.I_BANK1_SEL(bank1), .I_CTRL_REQ(ctrl_req), .I_SETUP_WR(setup_wr),
		.I_SETUP_RD(setup_rd), .I_SETUP_WDATA(setup_wdata), .I_INTR_OFF(evt[2]),
		.I_INTR_ON(evt[3]), .I_INTR_RET(evt[4]), .I_TOKEN_SEEN(evt[0]),
		.I_CONV_DONE(conv), .O_RDATA(rdata), .O_FIRST_PULSE_DUTY(duty1),
		.O_SECOND_PULSE_DUTY(duty2), .O_CONV_START(start), .O_CONV_BUSY(busy),
		.O_CONV_CHANNEL(chan), .O_CONV_P6_SEL(p6sel), .O_CONV_P7_SEL(p7sel),
		.O_NVM_OP(nvm_op), .O_NVM_OP_CYCLES(nvm_cyc), .O_WDOG_DIV(wdiv),
		.O_TICK_DIV(tdiv), .O_INTR_OFF(intr_q), .O_DATA_LINE_DIR(dl_dir),
		.O_PORT6_DIR(p6_dir));

	// free-running clock, hang guard
	always #20 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			$display("[ERR] %0t timeout", $time);
			wrap_up();
		end
	end

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	// compare, four-state
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// one write: held over one rising edge, gap cycle after
	task wr(input int k, input logic [3:0] a, input logic [7:0] d);
		@(negedge clk);
		file_req.addr = a;
		file_req.wdata = d;
		ctrl_req.addr = a;
		ctrl_req.wdata = d;
		setup_wdata = d;
		file_req.wr = (k == 0);
		ctrl_req.wr = (k == 1);
		setup_wr = (k == 2);
		@(negedge clk);
		file_req.wr = 1'b0;
		ctrl_req.wr = 1'b0;
		setup_wr = 1'b0;
	endtask : wr
	// one read, data checked the cycle after the strobe
	task rd(input int k, input logic [3:0] a, input logic [7:0] e);
		@(negedge clk);
		file_req.addr = a;
		ctrl_req.addr = a;
		file_req.rd = (k == 0);
		ctrl_req.rd = (k == 1);
		setup_rd = (k == 2);
		@(negedge clk);
		file_req.rd = 1'b0;
		ctrl_req.rd = 1'b0;
		setup_rd = 1'b0;
		chk(rdata, e);
	endtask : rd
	// one-cycle event pulse
	task pulse(input int i);
		@(negedge clk);
		evt[i] = 1'b1;
		conv.done = (i == 1);
		@(negedge clk);
		evt = '0;
		conv.done = 1'b0;
	endtask : pulse
	// verdict
	task wrap_up();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : wrap_up

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		arst_n = 1'b0;
		file_req = '0;
		ctrl_req = '0;
		bank1 = 1'b1;
		setup_wr = 1'b0;
		setup_rd = 1'b0;
		setup_wdata = 8'h00;
		evt = '0;
		conv = '0;
		last_res = 10'h000;
		repeat (3) @(negedge clk);
		arst_n = 1'b1;
		// reset outputs
		chk({wdiv, tdiv, intr_q}, {8'h80, 9'h100, 1'b0});
		chk({dl_dir, p6_dir, nvm_cyc}, {2'h3, 8'hFF, 22'd10});
		// every row: reset value, write, read back
		foreach (rows[i]) begin
			rd(rows[i].k, rows[i].a, rows[i].r);
			wr(rows[i].k, rows[i].a, rows[i].d);
			rd(rows[i].k, rows[i].a, rows[i].e);
		end
		chk({duty1, duty2, intr_q}, {8'h5A, 8'hA5, 1'b1});
		chk({dl_dir, p6_dir}, {2'h0, 8'h01});
		// bank 1 not selected: write ignored
		bank1 = 1'b0;
		wr(0, 4'h8, 8'h00);
		bank1 = 1'b1;
		rd(0, 4'h8, 8'h5A);
		// every memory command
		for (int i = 0; i < 4; i++) begin
			wr(0, 4'hE, 8'(i));
			chk({nvm_op, nvm_cyc}, {2'(i), 22'(cyc_exp[i])});
		end
		// every prescaler code
		for (int n = 0; n < 8; n++) begin
			wr(2, 4'h0, {2'b00, 3'(n), 3'(n)});
			chk({wdiv, tdiv}, {8'(1 << n), 9'(2 << n)});
		end
		// interrupt instructions against setup bit 6
		pulse(2);
		chk(intr_q, 1'b1);
		pulse(3);
		chk(intr_q, 1'b0);
		wr(2, 4'h0, 8'h40);
		chk(intr_q, 1'b1);
		pulse(4);
		chk(intr_q, 1'b0);
		// token flag sticks until a write clears it
		wr(0, 4'hA, 8'h02);
		pulse(0);
		rd(0, 4'hA, 8'h42);
		rd(0, 4'hA, 8'h42);
		wr(0, 4'hA, 8'h02);
		rd(0, 4'hA, 8'h02);
		// conversions across channel codes, incl. boundaries
		for (int j = 0; j < 7; j++) begin
			c = (j < 6) ? int'(j == 2 ? 8 : j == 3 ? 9 : j == 4 ? 16 : j == 5 ? 17 : j) : 5;
			res = {5'(c), 5'h15};
			wr(0, 4'hA, 8'h80 | 8'(c));
			chk({start, busy, chan}, {c >= 2 && c <= 16, c >= 2 && c <= 16, 5'(c)});
			chk(p6sel, (c >= 2 && c <= 8) ? 8'(1 << (c - 1)) : 8'h00);
			chk(p7sel, (c >= 9 && c <= 16) ? 8'(1 << (c - 9)) : 8'h00);
			if (busy === 1'b1) begin
				wr(0, 4'hA, 8'h80 | 8'(c));
				chk(start, 1'b0);
				last_res = res;
			end
			conv.result = res;
			pulse(1);
			chk(busy, 1'b0);
			rd(0, 4'hB, last_res[9:2]);
			rd(0, 4'hC, {last_res[1:0], 6'h00});
		end
		// token event and clearing write in one cycle: the event wins
		@(negedge clk);
		file_req.addr = 4'hA;
		file_req.wdata = 8'h02;
		file_req.wr = 1'b1;
		evt[0] = 1'b1;
		@(negedge clk);
		file_req.wr = 1'b0;
		evt = '0;
		rd(0, 4'hA, 8'h42);
		// off wins over on, both win over a setup write of bit 6
		@(negedge clk);
		evt[2] = 1'b1;
		evt[3] = 1'b1;
		setup_wdata = 8'h00;
		setup_wr = 1'b1;
		@(negedge clk);
		evt = '0;
		setup_wr = 1'b0;
		chk(intr_q, 1'b1);
		@(negedge clk);
		evt[3] = 1'b1;
		setup_wdata = 8'h40;
		setup_wr = 1'b1;
		@(negedge clk);
		evt = '0;
		setup_wr = 1'b0;
		chk(intr_q, 1'b0);
		// reset in mid-run: duty, channel, busy, setup, direction, memory and result back to reset values
		@(negedge clk);
		arst_n = 1'b0;
		@(negedge clk);
		chk({duty1, duty2, chan, busy}, {8'h00, 8'h00, 5'h00, 1'b0});
		chk({wdiv, tdiv, intr_q}, {8'h80, 9'h100, 1'b0});
		chk({dl_dir, p6_dir, nvm_cyc}, {2'h3, 8'hFF, 22'd10});
		arst_n = 1'b1;
		rd(0, 4'hB, 8'h00);
		wrap_up();
	end
endmodule : test_special_register_bank
